// >>> rtl/drc_pkg.sv
// Shared constants and carrier types for the dual-source reset control block.
// Assumes a single 40 MHz clock and a timer that supplies a carry set pulse.
package drc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned RESTART_MS      = 50;
    localparam int unsigned DEFAULT_PERIOD_MS = 100;
    localparam int unsigned RESTART_CYCLES  = (CLK_HZ / 1000) * RESTART_MS;

    // ****************************************************************
    // Reset values and entry point
    // ****************************************************************
    localparam logic [3:0]  RATE_RESET      = 4'h0;
    localparam logic [11:0] START_ADDR      = 12'h000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        DRC_RUN     = 4'b0001,
        DRC_CE_WAIT = 4'b0010,
        DRC_STOPPED = 4'b0100,
        DRC_HALTED  = 4'b1000
    } drc_state_t;

    typedef struct packed {
        logic halt_force_signal;
        logic ctrl_init_signal;
        logic core_init_signal;
    } drc_resets_t;

endpackage

// >>> rtl/drc_reset_control.sv
// Reset control for a 4-bit controller: power-on, chip-enable and clock stop.
// Assumes pins arrive asynchronously and the timer carry pulse is on this clock.
//
// What this block does
// - Power-on reset initialises PC, stack, system and all control registers; start 0000H.
// - Chip-enable reset initialises PC, stack, system and some control registers; start 0000H.
// - Core initialiser follows chip-enable rise at the next carry set pulse.
// - Forced halt for power-on and clock stop, not chip-enable; ends on carry.
// - Control initialiser for power-on and clock stop, not chip-enable alone.
// - Core initialiser for chip-enable, power-on and clock stop resets.
// - Without clock stop the timer rate keeps its value; reset on its carry.
// - Program keeps running between chip-enable rise and the carry pulse.
// - Clock stop instruction asserts all three reset signals at once.
// - Control initialiser clears timer rate to zero, giving a 100 ms period.
// - After clock stop with pin low, hold forced halt, oscillator stopped.
// - Chip-enable rise ends clock stop, restarts oscillator, start at first carry after the restart count.
// - After clock stop, chip-enable reset takes effect 50 ms after pin rise.
// - Chip-enable reset acts regardless of the instruction executing.
// - Power-on initialises all writable registers; chip-enable keeps data memory.
// - Power-on reset triggers as the supply rises past its threshold.
// - While supply low, stop oscillator and hold all three reset signals.
// - Clock stop instruction acts only with chip-enable low, else no-operation.
`timescale 1ns/100ps

module drc_reset_control
    import drc_pkg::*;
#(
    parameter int unsigned RESTART_COUNT = RESTART_CYCLES
) (
    input  wire logic        clock_in,
    input  wire logic        arst_n_in,
    // Pins from outside the clock domain.
    input  wire logic        chip_enable_in,
    input  wire logic        supply_low_signal_in,
    // Strobes from the core and the timer on this clock.
    input  wire logic        carry_flag_in,
    input  wire logic        stop_exec_in,
    input  wire logic [1:0]  rate_write_data_in,
    input  wire logic        rate_write_in,
    // Internal reset signals, oscillator control, data memory clear, timer rate and start address.
    output logic             halt_force_signal_out,
    output logic             ctrl_init_signal_out,
    output logic             core_init_signal_out,
    output logic             osc_enable_out,
    output logic             data_mem_clear_out,
    output logic [3:0]       timer_rate_out,
    output logic [11:0]      start_addr_out
);

    // ****************************************************************
    // Reset release and input synchronisers
    // ****************************************************************
    logic       rst_meta_reg;
    logic       rst_n_reg;
    logic [1:0] ce_sync_reg;
    logic [1:0] low_sync_reg;
    logic       ce_prev_reg;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // The supply-low copy resets high, so the block leaves reset as after power loss.
    // A pin already high reads as a rise, which lands inside the power-on halt.
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ce_sync_reg  <= 2'h0;
            low_sync_reg <= 2'h3;
            ce_prev_reg  <= 1'b0;
        end else begin
            ce_sync_reg  <= {ce_sync_reg[0], chip_enable_in};
            low_sync_reg <= {low_sync_reg[0], supply_low_signal_in};
            ce_prev_reg  <= ce_sync_reg[1];
        end
    end

    wire ce_level  = ce_sync_reg[1];
    wire ce_rise   = ce_level & ~ce_prev_reg;
    wire supply_lo = low_sync_reg[1];

    // ****************************************************************
    // Decode
    // ****************************************************************
    drc_state_t  state_reg;
    drc_state_t  state_next;
    logic        pending_reg;
    logic        pending_next;
    logic        por_reg;
    logic [3:0]  rate_reg;
    // A 32-bit count covers any restart delay at this clock; it only counts down.
    logic [31:0] wait_reg;
    logic [31:0] wait_next;
    drc_resets_t rs_reg;
    drc_resets_t rs_next;

    // Clock stop is a no-operation while the pin is high.
    wire stop_ok     = stop_exec_in & ~ce_level;
    wire wait_done   = (wait_reg == 32'h0);
    wire release_ok  = carry_flag_in & wait_done;
    // A rise that lands on the same carry pulse still counts: set beats clear.
    wire pend_set    = ce_rise;

    // ****************************************************************
    // State decode
    // ****************************************************************
    // Each decision is a named wire so that the sequencer below only routes them.
    // Power loss is handled ahead of all of these and overrides them.
    wire in_run       = (state_reg == DRC_RUN);
    wire in_stopped   = (state_reg == DRC_STOPPED);
    wire in_halted    = (state_reg == DRC_HALTED);
    // Clock stop wins over a pending chip-enable reset in the same cycle.
    wire stop_take    = in_run & stop_ok;
    wire ce_fire      = in_run & ~stop_ok & pending_reg & carry_flag_in;
    // The stopped state is left by a pin rise or on the way out of power loss.
    wire wake         = in_stopped & (ce_rise | por_reg);
    wire halt_release = in_halted & release_ok;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // All three internal resets at once.
    // Power loss and clock stop both need this pattern.
    function automatic drc_resets_t all_resets();
        drc_resets_t r;
        r.halt_force_signal = 1'b1;
        r.ctrl_init_signal  = 1'b1;
        r.core_init_signal  = 1'b1;
        return r;
    endfunction

    // Only the forced halt.
    // It stands while the restart count and the carry are awaited.
    function automatic drc_resets_t halt_only();
        drc_resets_t r;
        r                   = '0;
        r.halt_force_signal = 1'b1;
        return r;
    endfunction

    // Only the core initialiser, for a chip-enable reset while running.
    function automatic drc_resets_t core_only();
        drc_resets_t r;
        r                  = '0;
        r.core_init_signal = 1'b1;
        return r;
    endfunction

    // Down-counter step that sticks at zero rather than wrapping.
    // A wrap would turn a finished restart delay into a very long one.
    function automatic logic [31:0] count_down(input logic [31:0] value);
        logic [31:0] result;
        if (value != 32'h0) begin
            result = value - 32'h1;
        end else begin
            result = 32'h0;
        end
        return result;
    endfunction

    // Software selects only the two low rate bits; the upper two stay clear.
    function automatic logic [3:0] widen_rate(input logic [1:0] sel);
        return {2'h0, sel};
    endfunction

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        state_next   = state_reg;
        pending_next = pending_reg;
        wait_next    = count_down(wait_reg);
        rs_next      = '0;
        if (supply_lo) begin
            // Power loss overrides everything and rearms the restart count.
            state_next   = DRC_STOPPED;
            rs_next      = all_resets();
            pending_next = 1'b0;
            wait_next    = RESTART_COUNT;
        end else begin
            case (state_reg)
                DRC_RUN: begin
                    if (stop_take) begin
                        state_next = DRC_STOPPED;
                        rs_next    = all_resets();
                    end else if (ce_fire) begin
                        rs_next      = core_only();
                        pending_next = pend_set;
                    end else begin
                        // Program keeps running until the carry arrives.
                        pending_next = pending_reg | pend_set;
                    end
                end
                DRC_CE_WAIT: begin
                    // One settling cycle after release; a rise here is still kept.
                    state_next   = DRC_RUN;
                    pending_next = pending_reg | pend_set;
                end
                DRC_STOPPED: begin
                    // Oscillator is off; only a pin rise or power return moves on.
                    rs_next = all_resets();
                    if (wake) begin
                        state_next = DRC_HALTED;
                        wait_next  = RESTART_COUNT;
                    end
                end
                DRC_HALTED: begin
                    // Restart count first, then the carry; an early carry is ignored.
                    rs_next = halt_only();
                    if (halt_release) begin
                        state_next = DRC_CE_WAIT;
                        rs_next.core_init_signal = 1'b1;
                        pending_next = 1'b0;
                    end
                end
                default: begin
                    state_next = DRC_RUN;
                end
            endcase
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Out of reset the block behaves as after power loss: stopped, then halted.
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= DRC_STOPPED;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pending_reg <= 1'b0;
        end else begin
            pending_reg <= pending_next;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wait_reg <= 32'h0;
        end else begin
            wait_reg <= wait_next;
        end
    end

    // Reset outputs come from flops so that they never glitch.
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rs_reg <= '{1'b1, 1'b1, 1'b1};
        end else begin
            rs_reg <= rs_next;
        end
    end

    // Remembers whether the last entry into the stopped state was power-on.
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            por_reg <= 1'b1;
        end else if (supply_lo) begin
            por_reg <= 1'b1;
        end else if (in_halted) begin
            por_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Timer rate selection
    // ****************************************************************
    // A chip-enable reset alone leaves the rate untouched.
    wire rate_clear = rs_next.ctrl_init_signal;
    wire rate_load  = rate_write_in & ~rate_clear;

    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rate_reg <= RATE_RESET;
        end else if (rate_clear) begin
            rate_reg <= RATE_RESET;
        end else if (rate_load) begin
            rate_reg <= widen_rate(rate_write_data_in);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign halt_force_signal_out = rs_reg.halt_force_signal;
    assign ctrl_init_signal_out  = rs_reg.ctrl_init_signal;
    assign core_init_signal_out  = rs_reg.core_init_signal;
    // The oscillator runs in every state but the stopped one, halt included.
    assign osc_enable_out        = ~in_stopped;
    // Data memory is wiped only on power-on; a chip-enable reset keeps it.
    assign data_mem_clear_out    = rs_reg.ctrl_init_signal & por_reg;
    assign timer_rate_out        = rate_reg;
    assign start_addr_out        = START_ADDR;

endmodule

// >>> bench/drc_reset_control_monitor.sv
// Concurrent checks on the reset control block ports.
// Assumes it is bound to drc_reset_control and sees only its ports.
`timescale 1ns/100ps
module drc_reset_control_monitor
    import drc_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        arst_n_in,
    input wire logic        chip_enable_in,
    input wire logic        supply_low_signal_in,
    input wire logic        carry_flag_in,
    input wire logic        stop_exec_in,
    input wire logic        halt_force_signal_out,
    input wire logic        ctrl_init_signal_out,
    input wire logic        core_init_signal_out,
    input wire logic        osc_enable_out,
    input wire logic [3:0]  timer_rate_out,
    input wire logic [11:0] start_addr_out
);
    logic [3:0] ce_h;
    logic [5:0] sl_h;
    // A mixed reset pattern keeps both pin-level antecedents false until real history exists.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ce_h <= 4'h5;
            sl_h <= 6'h00;
        end else begin
            ce_h <= {ce_h[2:0], chip_enable_in};
            sl_h <= {sl_h[4:0], supply_low_signal_in};
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_all_set;
        halt_force_signal_out && ctrl_init_signal_out && core_init_signal_out && !osc_enable_out;
    endsequence
    chk_stop_sets_all: assert property (stop_exec_in && ce_h == 4'h0 && !chip_enable_in
        |=> s_all_set) else $error("stop did not assert all resets");
    chk_stop_ignored_high: assert property (stop_exec_in && ce_h == 4'hf && !halt_force_signal_out
        && sl_h == 6'h00 |=> !halt_force_signal_out && !ctrl_init_signal_out)
        else $error("stop acted with chip enable high");
    chk_supply_low_all: assert property (sl_h == 6'h3f |-> s_all_set)
        else $error("supply low did not hold resets");
    chk_core_one_pulse: assert property (core_init_signal_out && !halt_force_signal_out
        |=> !core_init_signal_out) else $error("core init longer than one cycle");
    chk_core_on_carry: assert property ($rose(core_init_signal_out) && !halt_force_signal_out
        |-> $past(carry_flag_in)) else $error("core init not after carry");
    chk_halt_ends_carry: assert property ($fell(halt_force_signal_out) |-> $past(carry_flag_in, 2))
        else $error("halt released without carry");
    chk_rate_cleared: assert property (ctrl_init_signal_out && $past(ctrl_init_signal_out)
        |-> timer_rate_out == RATE_RESET) else $error("rate not cleared");
    chk_osc_stop_halt: assert property (!osc_enable_out
        |-> halt_force_signal_out && ctrl_init_signal_out) else $error("stopped without halt");
    chk_start_addr: assert property (start_addr_out == START_ADDR)
        else $error("start address wrong");
endmodule
bind drc_reset_control drc_reset_control_monitor u_mon(.clock_in(clock_in), .arst_n_in(arst_n_in),
    .chip_enable_in(chip_enable_in), .supply_low_signal_in(supply_low_signal_in),
    .carry_flag_in(carry_flag_in), .stop_exec_in(stop_exec_in),
    .halt_force_signal_out(halt_force_signal_out), .ctrl_init_signal_out(ctrl_init_signal_out),
    .core_init_signal_out(core_init_signal_out), .osc_enable_out(osc_enable_out),
    .timer_rate_out(timer_rate_out), .start_addr_out(start_addr_out));

// >>> bench/drc_timer_model.sv
// Far-side timer that raises a one-cycle carry set pulse every PERIOD cycles.
// Assumes the oscillator enable from the block gates it, as a stopped crystal would.
`timescale 1ns/100ps
module drc_timer_model #(
    parameter int PERIOD = 40
) (
    input  wire logic clock_in,
    input  wire logic osc_in,
    output logic      carry_out
);
    int cnt = 0;
    initial carry_out = 1'b0;
    always @(posedge clock_in) begin
        cnt <= (!osc_in || cnt == PERIOD - 1) ? 0 : cnt + 1;
        carry_out <= osc_in && cnt == PERIOD - 1;
    end
endmodule

// >>> bench/tb_drc_reset_control.sv
// Self-checking bench for the reset control block.
// Assumes the timer model supplies carry pulses and the bench drives the pins.
`timescale 1ns/100ps
module tb_drc_reset_control;
    import drc_pkg::*;
    localparam int RC = 20;
    logic clock_in, arst_n_in, ce, sl, carry, stp, rw, halt, ctrl, core, osc, dmc;
    logic [1:0] rd;
    logic [3:0] rate;
    logic [11:0] sa;
    int err_total, total_checks, seed, n, exp_rate;
    int exp_q[$];
    drc_reset_control #(.RESTART_COUNT(RC)) DUT(.clock_in(clock_in), .arst_n_in(arst_n_in),
        .chip_enable_in(ce), .supply_low_signal_in(sl), .carry_flag_in(carry),
        .stop_exec_in(stp), .rate_write_data_in(rd), .rate_write_in(rw),
        .halt_force_signal_out(halt), .ctrl_init_signal_out(ctrl), .core_init_signal_out(core),
        .osc_enable_out(osc), .data_mem_clear_out(dmc), .timer_rate_out(rate),
        .start_addr_out(sa));
    drc_timer_model #(.PERIOD(40)) u_tmr(.clock_in(clock_in), .osc_in(osc), .carry_out(carry));
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait on a core init pulse (sel 0) or on halt release (sel 1).
    task wait_for(input int sel);
        n = 0;
        while (sel ? halt !== 1'b0 : core !== 1'b1) begin
            @(posedge clock_in);
            n++;
            if (n > 400) begin
                err_total++;
                end_of_test;
            end
        end
    endtask
    initial begin
        {arst_n_in, ce, sl, stp, rw, rd, err_total, total_checks, exp_rate} = '0;
        seed = 32'h86b4;
        repeat (6) @(posedge clock_in);
        arst_n_in <= 1'b1;
        wait_for(1);
        chk(n >= RC, 1);
        chk({osc, rate, sa}, {1'b1, 4'h0, START_ADDR});
        repeat (4) begin
            @(posedge clock_in);
            exp_rate = $random(seed) & 3;
            exp_q.push_back(exp_rate);
            rd <= exp_rate[1:0];
            rw <= 1'b1;
            @(posedge clock_in);
            rw <= 1'b0;
            repeat (3) @(posedge clock_in);
            chk(rate, exp_q.pop_front());
        end
        ce <= 1'b1;
        wait_for(0);
        chk({halt, ctrl, dmc, osc}, 4'h1);
        chk(rate[1:0], exp_rate);
        @(posedge clock_in);
        chk(core, 1'b0);
        stp <= 1'b1;
        @(posedge clock_in);
        stp <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk({halt, ctrl, osc}, 3'h1);
        ce <= 1'b0;
        repeat (5) @(posedge clock_in);
        stp <= 1'b1;
        @(posedge clock_in);
        stp <= 1'b0;
        repeat (60) @(posedge clock_in);
        chk({halt, ctrl, core, osc, rate}, 8'he0);
        ce <= 1'b1;
        wait_for(1);
        chk({n >= RC, osc, rate}, 6'h30);
        sl <= 1'b1;
        repeat (8) @(posedge clock_in);
        chk({halt, ctrl, core, osc, dmc}, 5'h1d);
        sl <= 1'b0;
        wait_for(1);
        chk({n >= RC, osc}, 2'h3);
        end_of_test;
    end
endmodule
